//--- sim/dmc_host_model.sv
/* host model: issues whole 16-bit control words to the mode registers.
   assumes words are taken on the rising edge of sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module dmc_host_model (
	input wire logic sys_clk,
	output logic word_valid,
	output dmc_pkg::dmc_word_t word_in
);
	import dmc_pkg::*;
	initial begin
		word_valid = 1'b0;
		word_in = 16'hA5A5;
	end
	// released bus flips so a stale word never looks valid by luck
	task automatic send(input logic rnw, input logic [6:0] idx, input logic [7:0] d);
		@(negedge sys_clk);
		word_valid = 1'b1;
		word_in = {rnw, idx, d};
		@(negedge sys_clk);
		word_valid = 1'b0;
		word_in = ~word_in;
	endtask : send
endmodule : dmc_host_model
`default_nettype wire

//--- sim/tb_dac_mode_control_registers.sv
/* testbench for the mode registers: one task per scenario.
   assumes the host model drives words and ZERO_RUN is shortened to 4. */
`timescale 1ns/1ps
`default_nettype none
module tb_dac_mode_control_registers;
	import dmc_pkg::*;
	logic sys_clk, rst, word_valid, hcr, strobe, read_valid, sco, all_zero;
	dmc_word_t word_in;
	logic [5:0] czero, flags;
	logic [7:0] read_data;
	dmc_settings_t st;
	int err_count = 0;
	int compares = 0;
	dmc_mode_regs #(.CHANNELS(6), .ZERO_RUN(4)) DUT (.sys_clk(sys_clk), .rst(rst),
		.word_valid(word_valid), .word_in(word_in), .high_clock_ratio(hcr),
		.sample_strobe(strobe), .channel_is_zero(czero), .read_data(read_data),
		.read_valid(read_valid), .system_clock_output(sco), .channel_zero_flag(flags),
		.all_zero_flag(all_zero), .settings(st));
	dmc_host_model host (.sys_clk(sys_clk), .word_valid(word_valid), .word_in(word_in));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		host.send(1'b0, idx, d);
	endtask : wr
	task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
		host.send(1'b1, idx, 8'h00);
		chk({7'h00, read_valid}, 8'h01);
		chk(read_data, exp);
	endtask : rd
	task automatic t_reset;
		wr(7'h20, 8'hFF);
		rd(7'h09, 8'h00);
		rd(7'h0A, 8'h00);
		rd(7'h0B, 8'h01);
		rd(7'h0C, 8'h00);
		rd(7'h20, 8'h00);
		chk({2'h0, flags}, 8'h00);
	endtask : t_reset
	task automatic t_format;
		logic [7:0] wl [8] = '{8'h18, 8'h14, 8'h12, 8'h10, 8'h18, 8'h18, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			wr(7'h09, 8'(i));
			chk({5'h00, st.audio_format}, 8'(i));
			chk({3'h0, st.word_length}, wl[i]);
		end
		wr(7'h09, 8'h20);
		chk({7'h00, st.rolloff_select}, 8'h01);
		rd(7'h09, 8'h20);
	endtask : t_format
	task automatic t_deemph;
		for (int r = 0; r < 4; r++) begin
			wr(7'h0A, 8'(r << 3));
			chk({6'h00, st.deemphasis_rate}, 8'(r));
		end
		for (int d = 0; d < 8; d++) begin
			wr(7'h0A, 8'(d));
			chk({7'h00, st.deemphasis_on}, {7'h00, d != 0});
		end
		wr(7'h0A, 8'h20);
		chk({7'h00, st.output_phase_invert}, 8'h01);
		wr(7'h0B, 8'h86);
		chk({7'h00, st.auto_increment}, 8'h01);
		chk({1'b0, st.register_index}, 8'h06);
		rd(7'h0B, 8'h86);
	endtask : t_deemph
	task automatic t_over;
		logic [7:0] ov [4] = '{8'h20, 8'h40, 8'h40, 8'h80};
		for (int i = 0; i < 4; i++) begin
			@(negedge sys_clk);
			hcr = i[1];
			wr(7'h0C, {i[0], 7'h00});
			chk(st.oversampling_ratio, ov[i]);
		end
		wr(7'h0C, 8'h00);
	endtask : t_over
	task automatic t_clock;
		logic [7:0] cfg [3] = '{8'h00, 8'h10, 8'h08};
		logic [7:0] exp [3] = '{8'h10, 8'h08, 8'h00};
		logic prev;
		logic [7:0] n;
		for (int m = 0; m < 3; m++) begin
			wr(7'h09, cfg[m]);
			@(negedge sys_clk);
			prev = sco;
			n = 8'h00;
			repeat (32) begin
				@(negedge sys_clk);
				if (sco && !prev) n++;
				prev = sco;
			end
			chk(n, exp[m]);
		end
		chk({7'h00, sco}, 8'h00);
		wr(7'h09, 8'h00);
	endtask : t_clock
	task automatic pulse(input int k);
		repeat (k) begin
			@(negedge sys_clk);
			strobe = 1'b1;
			@(negedge sys_clk);
			strobe = 1'b0;
		end
		repeat (2) @(negedge sys_clk);
	endtask : pulse
	task automatic t_zero;
		czero = 6'h3F;
		pulse(3);
		chk({1'b0, all_zero, flags}, 8'h00);
		pulse(1);
		chk({1'b0, all_zero, flags}, 8'h7F);
		wr(7'h0A, 8'h40);
		repeat (2) @(negedge sys_clk);
		chk({1'b0, all_zero, flags}, 8'h00);
		wr(7'h0A, 8'h00);
		czero = 6'h3E;
		pulse(1);
		chk({1'b0, all_zero, flags}, 8'h3E);
		wr(7'h0C, 8'h55);
		repeat (2) @(negedge sys_clk);
		chk({2'h0, flags}, 8'h15);
		wr(7'h0C, 8'h00);
		repeat (2) @(negedge sys_clk);
		chk({2'h0, flags}, 8'h3E);
	endtask : t_zero
	task automatic stop_test;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		rst = 1'b1;
		hcr = 1'b0;
		strobe = 1'b0;
		czero = 6'h00;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		t_reset();
		t_format();
		t_deemph();
		t_over();
		t_clock();
		t_zero();
		stop_test();
	end
endmodule : tb_dac_mode_control_registers
`default_nettype wire

//--- verilog/dmc_map.svh
/*
 * Register indices, field positions, reset values and counts for the DAC mode control registers.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH

`define DMC_IDX_FILTER_CLOCK_FORMAT 7'h09
`define DMC_IDX_FLAG_PHASE_DEEMPH 7'h0A
`define DMC_IDX_READBACK 7'h0B
`define DMC_IDX_OVERSAMPLING_GPO 7'h0C

`define DMC_WORD_RW_BIT 15
`define DMC_WORD_IDX_HI 14
`define DMC_WORD_IDX_LO 8

`define DMC_RST_FILTER_CLOCK_FORMAT 8'h00
`define DMC_RST_FLAG_PHASE_DEEMPH 8'h00
`define DMC_RST_READBACK 8'h01
`define DMC_RST_OVERSAMPLING_GPO 8'h00

`define DMC_FMT_RJ24 3'h0
`define DMC_FMT_RJ20 3'h1
`define DMC_FMT_RJ18 3'h2
`define DMC_FMT_RJ16 3'h3
`define DMC_FMT_I2S 3'h4
`define DMC_FMT_LJ 3'h5

`define DMC_ZERO_RUN_SAMPLES 1024
`define DMC_CHANNELS 6

`endif

//--- verilog/dmc_mode_regs.sv
/*
 * Upper control registers of a six-channel audio DAC: decode of control words, readback,
 * clock output, zero flags with per-channel zero-run detection, and general-purpose outputs.
 * Assumes the serial port deframer delivers one whole 16-bit word per word_valid pulse,
 * synchronous to sys_clk; sample_strobe marks one sample period.
 */
// What this block does
// - rolloff select 0 gives sharp filter rolloff, 1 gives slow rolloff.
// - clock output runs at half the input clock rate, or a quarter rate when divide bit set.
// - clock output disable 1 holds the clock output low; 0 lets it toggle.
// - format codes 000-011 give right-justified 24, 20, 18, 16-bit words.
// - code 100 selects I2S, 101 left-justified; 110 and 111 reserved.
// - flag polarity 0 makes flags high on zero detect, 1 makes them low.
// - phase select 1 inverts the output sample stream; 0 leaves it normal.
// - de-emphasis rate 00 is 44.1 kHz, 01 48 kHz, 10 32 kHz, 11 reserved.
// - de-emphasis is on for all channels when any of three enable bits is set.
// - auto-increment bit 1 enables auto-increment reads; 0 only single reads.
// - read index, default 01h, names single read register or last auto-increment one.
// - oversampling bit picks 64x/128x at high clock ratios, 32x/64x at 128 or 192 fs.
// - gp output enable puts gp bits on the six channel flag pins instead of zero flags; the all-zero flag is unaffected.
// - in gp mode each pin drives the written gp bit level; bits reset to 0.
// - control word is read flag bit 15, index bits 14-8, data bits 7-0.
// - a channel is zero after 1024 consecutive zero sample periods.
// - the all-zero flag is the AND of all six channel zero detects, inverted when flag polarity is 1.
`include "dmc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module dmc_mode_regs #(
	parameter int CHANNELS = `DMC_CHANNELS,
	parameter int ZERO_RUN = `DMC_ZERO_RUN_SAMPLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic word_valid,
	input wire dmc_pkg::dmc_word_t word_in,
	input wire logic high_clock_ratio,
	input wire logic sample_strobe,
	input wire logic [CHANNELS-1:0] channel_is_zero,
	output logic [7:0] read_data,
	output logic read_valid,
	output logic system_clock_output,
	output logic [CHANNELS-1:0] channel_zero_flag,
	output logic all_zero_flag,
	output dmc_pkg::dmc_settings_t settings
);
	import dmc_pkg::*;

	localparam int RUN_W = $clog2(ZERO_RUN + 1);

	logic [7:0] fcf_q;
	logic [7:0] fpd_q;
	logic [7:0] rbc_q;
	logic [7:0] ogp_q;
	logic [7:0] read_data_q;
	logic read_valid_q;
	logic clk_div_q;
	logic clk_out_q;
	logic [RUN_W-1:0] run_q [CHANNELS];
	logic [CHANNELS-1:0] detect_q;
	logic [CHANNELS-1:0] pin_q;
	logic all_zero_q;

	// word decode: bit 15 selects read, bits 14:8 select the register
	wire logic is_write = word_valid && !word_in.read_not_write;
	wire logic is_read = word_valid && word_in.read_not_write;
	wire logic wr_fcf = is_write && word_in.register_index == `DMC_IDX_FILTER_CLOCK_FORMAT;
	wire logic wr_fpd = is_write && word_in.register_index == `DMC_IDX_FLAG_PHASE_DEEMPH;
	wire logic wr_rbc = is_write && word_in.register_index == `DMC_IDX_READBACK;
	wire logic wr_ogp = is_write && word_in.register_index == `DMC_IDX_OVERSAMPLING_GPO;

	// field views
	wire logic rolloff_select = fcf_q[5];
	wire logic clock_out_divide = fcf_q[4];
	wire logic clock_out_disable = fcf_q[3];
	wire dmc_format_t audio_format = dmc_format_t'(fcf_q[2:0]);
	wire logic flag_polarity = fpd_q[6];
	wire logic output_phase_invert = fpd_q[5];
	wire dmc_deemph_t deemphasis_rate = dmc_deemph_t'(fpd_q[4:3]);
	wire logic [2:0] deemphasis_enable = fpd_q[2:0];
	wire logic auto_increment = rbc_q[7];
	wire logic [6:0] register_index = rbc_q[6:0];
	wire logic oversampling_select = ogp_q[7];
	wire logic gp_output_enable = ogp_q[6];
	wire logic [5:0] gp_output_bit = ogp_q[5:0];

	function automatic logic [7:0] reg_lookup(input logic [6:0] idx, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			`DMC_IDX_FILTER_CLOCK_FORMAT: v = a;
			`DMC_IDX_FLAG_PHASE_DEEMPH: v = b;
			`DMC_IDX_READBACK: v = c;
			`DMC_IDX_OVERSAMPLING_GPO: v = d;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : reg_lookup

	// registers outside this bank (attenuation, mute, enable) read as zero here
	wire logic [7:0] read_d = reg_lookup(word_in.register_index, fcf_q, fpd_q, rbc_q, ogp_q);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fcf_q <= `DMC_RST_FILTER_CLOCK_FORMAT;
			fpd_q <= `DMC_RST_FLAG_PHASE_DEEMPH;
			rbc_q <= `DMC_RST_READBACK;
			ogp_q <= `DMC_RST_OVERSAMPLING_GPO;
		end else begin
			// all data bits stored as written, reserved test bits included
			if (wr_fcf) fcf_q <= word_in.data;
			if (wr_fpd) fpd_q <= word_in.data;
			if (wr_rbc) rbc_q <= word_in.data;
			if (wr_ogp) ogp_q <= word_in.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			read_data_q <= 8'h00;
			read_valid_q <= 1'b0;
		end else begin
			read_valid_q <= is_read;
			if (is_read) read_data_q <= read_d;
		end
	end

	assign read_data = read_data_q;
	assign read_valid = read_valid_q;

	// word length per format; I2S and left-justified accept up to 24 bits
	function automatic logic [4:0] fmt_length(input dmc_format_t f);
		logic [4:0] n;
		n = 5'h18;
		case (f)
			DMC_FMT_RJ24_E: n = 5'h18;
			DMC_FMT_RJ20_E: n = 5'h14;
			DMC_FMT_RJ18_E: n = 5'h12;
			DMC_FMT_RJ16_E: n = 5'h10;
			DMC_FMT_I2S_E, DMC_FMT_LJ_E: n = 5'h18;
			default: n = 5'h00;
		endcase
		return n;
	endfunction : fmt_length

	wire logic [7:0] osr = high_clock_ratio ? (oversampling_select ? 8'h80 : 8'h40)
		: (oversampling_select ? 8'h40 : 8'h20);

	assign settings.rolloff_select = rolloff_select;
	assign settings.audio_format = audio_format;
	assign settings.word_length = fmt_length(audio_format);
	assign settings.output_phase_invert = output_phase_invert;
	assign settings.deemphasis_rate = deemphasis_rate;
	assign settings.deemphasis_on = |deemphasis_enable;
	assign settings.auto_increment = auto_increment;
	assign settings.register_index = register_index;
	assign settings.oversampling_ratio = osr;

	// a register cannot toggle at sys_clk itself, so full rate is sys_clk/2 and
	// half rate sys_clk/4; the ratio between the two settings is kept
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clk_div_q <= 1'b0;
			clk_out_q <= 1'b0;
		end else begin
			clk_div_q <= ~clk_div_q;
			if (clock_out_disable) clk_out_q <= 1'b0;
			else if (clock_out_divide) clk_out_q <= clk_div_q ? ~clk_out_q : clk_out_q;
			else clk_out_q <= ~clk_out_q;
		end
	end

	assign system_clock_output = clk_out_q;

	// zero-run counters saturate so a long silence keeps the flag set
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int c = 0; c < CHANNELS; c++) begin
				run_q[c] <= '0;
			end
			detect_q <= '0;
		end else if (sample_strobe) begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (!channel_is_zero[c]) begin
					run_q[c] <= '0;
					detect_q[c] <= 1'b0;
				end else if (run_q[c] < RUN_W'(ZERO_RUN)) begin
					run_q[c] <= run_q[c] + RUN_W'(1);
					detect_q[c] <= (run_q[c] == RUN_W'(ZERO_RUN - 1));
				end
			end
		end
	end

	wire logic [CHANNELS-1:0] zero_level = flag_polarity ? ~detect_q : detect_q;
	wire logic [CHANNELS-1:0] pin_d = gp_output_enable ? gp_output_bit[CHANNELS-1:0] : zero_level;
	wire logic all_d = flag_polarity ? ~(&detect_q) : (&detect_q);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_q <= '0;
			all_zero_q <= 1'b0;
		end else begin
			pin_q <= pin_d;
			all_zero_q <= all_d;
		end
	end

	assign channel_zero_flag = pin_q;
	assign all_zero_flag = all_zero_q;

	a_write_stores: assert property (@(posedge sys_clk) disable iff (rst)
		wr_fcf |=> fcf_q == $past(word_in.data)) else $error("register write not stored");

	a_read_returns: assert property (@(posedge sys_clk) disable iff (rst)
		is_read && word_in.register_index == `DMC_IDX_READBACK && !wr_rbc |=> read_valid && read_data == rbc_q)
		else $error("readback mismatch");

	a_clk_held_low: assert property (@(posedge sys_clk) disable iff (rst)
		clock_out_disable [*2] |-> !system_clock_output) else $error("clock output not held low");

	a_clk_full_rate: assert property (@(posedge sys_clk) disable iff (rst)
		(!clock_out_disable && !clock_out_divide) ##1 (!clock_out_disable && !clock_out_divide)
		|-> system_clock_output != $past(system_clock_output)) else $error("full-rate clock not toggling");

	// half rate holds each level for two edges, so the level two edges back always differs
	sequence s_half_rate;
		(!clock_out_disable && clock_out_divide) [*3];
	endsequence
	a_clk_half_rate: assert property (@(posedge sys_clk) disable iff (rst)
		s_half_rate |-> system_clock_output != $past(system_clock_output, 2))
		else $error("half-rate clock wrong");

	a_gp_mode_pins: assert property (@(posedge sys_clk) disable iff (rst)
		gp_output_enable && !wr_ogp |=> channel_zero_flag == gp_output_bit[CHANNELS-1:0])
		else $error("gp bits not on flag pins");

	a_all_zero_and: assert property (@(posedge sys_clk) disable iff (rst)
		!flag_polarity && !wr_fpd |=> all_zero_flag == &$past(detect_q)) else $error("all-zero flag wrong");

	a_zero_polarity: assert property (@(posedge sys_clk) disable iff (rst)
		!gp_output_enable && flag_polarity && !wr_ogp && !wr_fpd |=> channel_zero_flag == ~$past(detect_q))
		else $error("flag polarity wrong");

	a_zero_clears: assert property (@(posedge sys_clk) disable iff (rst)
		sample_strobe && channel_is_zero[0] == 1'b0 |=> !detect_q[0]) else $error("zero flag not cleared");

	a_deemph_or: assert property (@(posedge sys_clk) disable iff (rst)
		wr_fpd |=> settings.deemphasis_on == |$past(word_in.data[2:0])) else $error("de-emphasis enable wrong");

	a_osr_select: assert property (@(posedge sys_clk) disable iff (rst)
		!high_clock_ratio && oversampling_select |-> settings.oversampling_ratio == 8'h40)
		else $error("oversampling ratio wrong");

	// indices outside this bank, seen by the checks on refused words
	wire logic idx_unmapped = word_in.register_index < `DMC_IDX_FILTER_CLOCK_FORMAT
		|| word_in.register_index > `DMC_IDX_OVERSAMPLING_GPO;

	a_read_pulse_once: assert property (@(posedge sys_clk) disable iff (rst)
		!is_read |=> !read_valid)
		else $error("read valid without a read word");

	a_read_unmapped: assert property (@(posedge sys_clk) disable iff (rst)
		is_read && idx_unmapped |=> read_data == 8'h00)
		else $error("unmapped read not zero");

	a_write_ignored: assert property (@(posedge sys_clk) disable iff (rst)
		is_write && idx_unmapped |=> $stable(fcf_q) && $stable(fpd_q) && $stable(rbc_q) && $stable(ogp_q))
		else $error("unmapped write changed a register");

	a_format_rj16: assert property (@(posedge sys_clk) disable iff (rst)
		audio_format == DMC_FMT_RJ16_E |-> settings.word_length == 5'h10)
		else $error("16-bit format length wrong");

	a_format_wide: assert property (@(posedge sys_clk) disable iff (rst)
		audio_format == DMC_FMT_I2S_E || audio_format == DMC_FMT_LJ_E |-> settings.word_length == 5'h18)
		else $error("wide format length wrong");

	a_rolloff_stored: assert property (@(posedge sys_clk) disable iff (rst)
		wr_fcf |=> settings.rolloff_select == $past(word_in.data[5]))
		else $error("rolloff select wrong");

	a_phase_stored: assert property (@(posedge sys_clk) disable iff (rst)
		wr_fpd |=> settings.output_phase_invert == $past(word_in.data[5]))
		else $error("phase select wrong");

	a_deemph_rate: assert property (@(posedge sys_clk) disable iff (rst)
		wr_fpd |=> settings.deemphasis_rate == $past(word_in.data[4:3]))
		else $error("de-emphasis rate wrong");

	a_readback_fields: assert property (@(posedge sys_clk) disable iff (rst)
		wr_rbc |=> settings.auto_increment == $past(word_in.data[7])
		&& settings.register_index == $past(word_in.data[6:0]))
		else $error("readback control fields wrong");

	a_gp_bits_level: assert property (@(posedge sys_clk) disable iff (rst)
		wr_ogp && word_in.data[6] |-> ##2 channel_zero_flag == $past(word_in.data[5:0], 2))
		else $error("gp pin level wrong");

	a_zero_run_sets: assert property (@(posedge sys_clk) disable iff (rst)
		sample_strobe && channel_is_zero[0] && run_q[0] == RUN_W'(ZERO_RUN - 1) |=> detect_q[0])
		else $error("zero detect not set at end of run");

	a_zero_not_early: assert property (@(posedge sys_clk) disable iff (rst)
		sample_strobe && run_q[0] < RUN_W'(ZERO_RUN - 1) |=> !detect_q[0])
		else $error("zero detect set too early");

	a_reset_values: assert property (@(posedge sys_clk)
		$fell(rst) |-> fcf_q == `DMC_RST_FILTER_CLOCK_FORMAT && fpd_q == `DMC_RST_FLAG_PHASE_DEEMPH
		&& rbc_q == `DMC_RST_READBACK && ogp_q == `DMC_RST_OVERSAMPLING_GPO && !read_valid && !system_clock_output)
		else $error("reset defaults wrong");

endmodule : dmc_mode_regs

`default_nettype wire

//--- verilog/dmc_pkg.sv
/*
 * Types shared by the DAC mode control register logic.
 * Assumes dmc_map.svh constants; no logic of its own.
 */
`default_nettype none

package dmc_pkg;

	typedef enum logic [2:0] {
		DMC_FMT_RJ24_E = 3'b000,
		DMC_FMT_RJ20_E = 3'b001,
		DMC_FMT_RJ18_E = 3'b010,
		DMC_FMT_RJ16_E = 3'b011,
		DMC_FMT_I2S_E = 3'b100,
		DMC_FMT_LJ_E = 3'b101,
		DMC_FMT_RSV6_E = 3'b110,
		DMC_FMT_RSV7_E = 3'b111
	} dmc_format_t;

	typedef enum logic [1:0] {
		DMC_DEEMPH_44K1_E = 2'b00,
		DMC_DEEMPH_48K_E = 2'b01,
		DMC_DEEMPH_32K_E = 2'b10,
		DMC_DEEMPH_RSV_E = 2'b11
	} dmc_deemph_t;

	// control word from the serial port deframer
	typedef struct packed {
		logic read_not_write;
		logic [6:0] register_index;
		logic [7:0] data;
	} dmc_word_t;

	// settings handed to the filter, interface and modulator logic
	typedef struct packed {
		logic rolloff_select;
		dmc_format_t audio_format;
		logic [4:0] word_length;
		logic output_phase_invert;
		dmc_deemph_t deemphasis_rate;
		logic deemphasis_on;
		logic auto_increment;
		logic [6:0] register_index;
		logic [7:0] oversampling_ratio;
	} dmc_settings_t;

endpackage : dmc_pkg

`default_nettype wire
